// *** inc/bsw_pkg.sv ***
// Package of constants and types for the switch telegram builder.
package bsw_pkg;
	localparam int ADDR_BYTES = 6;
	localparam int HDR_BYTES = 2;
	localparam int CRC_BYTES = 3;
	localparam int KEY_BYTES = 16;
	localparam int SEQ_BYTES = 4;
	localparam int SIG_BYTES = 4;
	localparam int OPT_MAX_BYTES = 4;
	localparam int AUTH_BYTES = 13;
	localparam logic [1:0] PRAND_TAG = 2'h2;
	localparam int PRAND_RND_BITS = 22;
	localparam int HALF_ADDR_BITS = 24;
	localparam logic [7:0] HDR_ADV_BYTE = 8'h42;
	localparam logic [7:0] TYPE_MFR_DATA = 8'hFF;
	localparam logic [7:0] LEN_DATA_BASE = 8'h0C;
	localparam logic [7:0] LEN_COMMISSION = 8'h1D;
	localparam logic [2:0] STATUS_RSVD = 3'h0;
	localparam logic [23:0] CRC_POLY = 24'h00_065B;
	localparam logic [23:0] CRC_INIT = 24'h55_5555;
	localparam logic [31:0] SEQ_RESET = 32'h0000_0000;
	localparam logic [21:0] PRAND_SEED = 22'h15_A5A5;
	localparam logic [21:0] PRAND_TAPS = 22'h20_0001;
	// Field byte offsets inside the payload.
	localparam int P_LEN = 0;
	localparam int P_TYPE = 1;
	localparam int P_MFR = 2;
	localparam int P_SEQ = 4;
	localparam int P_STATUS = 8;
	localparam int P_OPT = 9;
	localparam int P_KEY = 8;
	localparam int P_SADDR = 24;
	typedef enum logic [1:0] {
		BSW_OPT0,
		BSW_OPT1,
		BSW_OPT2,
		BSW_OPT4
	} bsw_opt_t;
	typedef enum logic {
		BSW_CIPH_HASH,
		BSW_CIPH_SIGN
	} bsw_ciph_t;
endpackage

// *** hw/bsw_prand_gen.sv ***
// Free-running prand source for rotating private addresses.
`timescale 1ns/100ps
`default_nettype none
module bsw_prand_gen (
	input wire logic core_clk,
	input wire logic sys_rst,
	output logic [23:0] prand
);
	import bsw_pkg::*;
	typedef struct packed {
		logic [21:0] lfsr_q;
	} bsw_prand_st_t;
	bsw_prand_st_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.lfsr_q = {st_q.lfsr_q[20:0], ^(st_q.lfsr_q & PRAND_TAPS)};
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '{lfsr_q: PRAND_SEED};
		end else begin
			st_q <= st_d;
		end
	end
	// Seed is a constant, so a real part should mix in entropy at power-up.
	assign prand = {PRAND_TAG, st_q.lfsr_q};
endmodule
`default_nettype wire

// *** hw/bsw_crc24.sv ***
// Byte-wide 24-bit link CRC, bits taken least significant first.
`timescale 1ns/100ps
`default_nettype none
module bsw_crc24 (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic crc_init,
	input wire logic byte_en,
	input wire logic [7:0] byte_in,
	output logic [23:0] crc_next
);
	import bsw_pkg::*;
	typedef struct packed {
		logic [23:0] crc_q;
	} bsw_crc_st_t;
	bsw_crc_st_t st_q, st_d;
	function automatic logic [23:0] crc_byte(input logic [23:0] c,
		input logic [7:0] b);
		logic [23:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			fb = r[23] ^ b[i];
			r = {r[22:0], 1'b0} ^ (fb ? CRC_POLY : 24'h00_0000);
		end
		return r;
	endfunction
	always_comb begin
		st_d = st_q;
		if (crc_init) begin
			st_d.crc_q = CRC_INIT;
		end else if (byte_en) begin
			st_d.crc_q = crc_byte(st_q.crc_q, byte_in);
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '{crc_q: CRC_INIT};
		end else begin
			st_q <= st_d;
		end
	end
	assign crc_next = st_d.crc_q;
endmodule
`default_nettype wire

// *** hw/bsw_telegram_builder.sv ***
// Telegram builder: address, payload and check fields as a byte stream.
`timescale 1ns/100ps
`default_nettype none
module bsw_telegram_builder #(
	// Device-type code; the value is arbitrary.
	parameter logic [15:0] DEV_TYPE_CODE = 16'h5AA5,
	// Default manufacturer code; the value is arbitrary.
	parameter logic [15:0] MFR_CODE_DEFAULT = 16'h1234
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic stroke_valid,
	input wire logic stroke_press,
	input wire logic first_a,
	input wire logic second_a,
	input wire logic first_b,
	input wire logic second_b,
	input wire logic commission_req,
	input wire logic rotating_address_select,
	input wire logic [31:0] static_addr_low,
	input wire logic [127:0] device_key,
	input wire logic irk_override_en,
	input wire logic [127:0] irk_cfg,
	input wire logic mfr_override_en,
	input wire logic [15:0] mfr_code_cfg,
	input wire bsw_pkg::bsw_opt_t opt_size,
	input wire logic [31:0] opt_data,
	output logic cipher_start,
	output bsw_pkg::bsw_ciph_t cipher_mode,
	output logic [127:0] cipher_key,
	output logic [127:0] cipher_block,
	output logic [103:0] cipher_auth,
	input wire logic cipher_done,
	input wire logic [127:0] cipher_result,
	output logic out_valid,
	output logic [7:0] out_byte,
	output logic out_last,
	input wire logic out_ready,
	output logic busy,
	output logic [31:0] seq_count
);
	import bsw_pkg::*;
	typedef enum logic [2:0] {
		S_IDLE,
		S_DIR,
		S_SAMPLE,
		S_HASH,
		S_SIGN,
		S_SEND
	} bsw_state_t;
	typedef struct packed {
		bsw_state_t state;
		logic commission;
		logic press;
		logic [3:0] held;
		logic [7:0] status;
		logic [31:0] seq;
		logic [23:0] prand;
		logic [23:0] hash;
		logic rotating;
		logic [31:0] sig;
		logic [5:0] idx;
		logic [7:0] obyte;
		logic ciph_pend;
	} bsw_st_t;
	bsw_st_t st_q, st_d;
	logic [23:0] prand_now;
	logic [23:0] crc_next;
	logic [47:0] static_addr;
	logic [47:0] tx_addr;
	logic [127:0] irk;
	logic [15:0] mfr;
	logic [7:0] len_byte;
	logic [5:0] opt_bytes;
	logic [5:0] pay_bytes;
	logic [5:0] crc_at;
	logic [5:0] last_at;
	logic accept;
	bsw_prand_gen u_prand (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.prand(prand_now)
	);
	bsw_crc24 u_crc (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.crc_init(st_q.state == S_IDLE),
		.byte_en(accept && (st_q.idx < crc_at)),
		.byte_in(st_q.obyte),
		.crc_next(crc_next)
	);
	function automatic logic [5:0] opt_len(input bsw_opt_t s);
		unique case (s)
			BSW_OPT0: return 6'd0;
			BSW_OPT1: return 6'd1;
			BSW_OPT2: return 6'd2;
			BSW_OPT4: return 6'd4;
		endcase
	endfunction
	assign static_addr = {DEV_TYPE_CODE, static_addr_low};
	// Commissioning never rotates, as it must reveal the identity.
	assign tx_addr = (st_q.rotating && !st_q.commission) ?
		{st_q.prand, st_q.hash} : static_addr;
	assign irk = irk_override_en ? irk_cfg : device_key;
	assign mfr = mfr_override_en ? mfr_code_cfg : MFR_CODE_DEFAULT;
	assign opt_bytes = opt_len(opt_size);
	assign len_byte = st_q.commission ? LEN_COMMISSION :
		LEN_DATA_BASE + {2'h0, opt_bytes};
	assign pay_bytes = 6'(len_byte) + 6'd1;
	assign crc_at = 6'(HDR_BYTES + ADDR_BYTES) + pay_bytes;
	assign last_at = crc_at + 6'(CRC_BYTES - 1);
	assign accept = (st_q.state == S_SEND) && out_ready;
	// Payload byte by offset; multi-byte fields go least significant first.
	function automatic logic [7:0] pay_at(input logic [5:0] p);
		logic [7:0] b;
		b = 8'h00;
		if (p == 6'(P_LEN)) begin
			b = len_byte;
		end else if (p == 6'(P_TYPE)) begin
			b = TYPE_MFR_DATA;
		end else if (p < 6'(P_SEQ)) begin
			b = mfr[8*(p-6'(P_MFR)) +: 8];
		end else if (p < 6'(P_STATUS)) begin
			b = st_q.seq[8*(p-6'(P_SEQ)) +: 8];
		end else if (st_q.commission) begin
			if (p < 6'(P_SADDR)) begin
				b = device_key[8*(p-6'(P_KEY)) +: 8];
			end else begin
				b = static_addr[8*(p-6'(P_SADDR)) +: 8];
			end
		end else if (p == 6'(P_STATUS)) begin
			b = st_q.status;
		end else if (p < 6'(P_OPT) + opt_bytes) begin
			b = opt_data[8*(p-6'(P_OPT)) +: 8];
		end else begin
			b = st_q.sig[8*(p-6'(P_OPT)-opt_bytes) +: 8];
		end
		return b;
	endfunction
	function automatic logic [7:0] frame_at(input logic [5:0] i,
		input logic [23:0] crc);
		logic [7:0] b;
		b = 8'h00;
		if (i == 6'd0) begin
			b = HDR_ADV_BYTE;
		end else if (i == 6'd1) begin
			b = 8'(pay_bytes) + 8'(ADDR_BYTES);
		end else if (i < 6'(HDR_BYTES + ADDR_BYTES)) begin
			b = tx_addr[8*(i-6'(HDR_BYTES)) +: 8];
		end else if (i < crc_at) begin
			b = pay_at(i - 6'(HDR_BYTES + ADDR_BYTES));
		end else begin
			b = crc[8*(i-crc_at) +: 8];
		end
		return b;
	endfunction
	always_comb begin
		logic [103:0] auth;
		auth = '0;
		for (int k = 0; k < AUTH_BYTES; k++) begin
			auth[8*k +: 8] = (k < P_OPT + int'(opt_bytes)) ?
				pay_at(6'(k)) : 8'h00;
		end
		st_d = st_q;
		cipher_start = 1'b0;
		cipher_mode = BSW_CIPH_HASH;
		cipher_block = {104'h0, st_q.prand};
		cipher_auth = auth;
		unique case (st_q.state)
			S_IDLE: begin
				// Requests while busy are dropped, never queued.
				if (commission_req) begin
					st_d.commission = 1'b1;
					st_d.state = S_SEND;
					st_d.idx = '0;
				end else if (stroke_valid) begin
					st_d.commission = 1'b0;
					st_d.state = S_DIR;
				end
			end
			S_DIR: begin
				st_d.press = stroke_press;
				st_d.state = S_SAMPLE;
			end
			S_SAMPLE: begin
				// Release reports what the press reported.
				if (st_q.press) begin
					st_d.held = {second_b, first_b, second_a, first_a};
				end
				st_d.status = {STATUS_RSVD,
					st_q.press ? {second_b, first_b, second_a, first_a} :
					st_q.held, st_q.press};
				st_d.rotating = rotating_address_select;
				st_d.prand = prand_now;
				st_d.ciph_pend = 1'b1;
				st_d.state = rotating_address_select ? S_HASH : S_SIGN;
			end
			S_HASH: begin
				cipher_start = st_q.ciph_pend;
				st_d.ciph_pend = 1'b0;
				if (cipher_done && !st_q.ciph_pend) begin
					st_d.hash = cipher_result[HALF_ADDR_BITS-1:0];
					st_d.ciph_pend = 1'b1;
					st_d.state = S_SIGN;
				end
			end
			S_SIGN: begin
				cipher_mode = BSW_CIPH_SIGN;
				cipher_block = {tx_addr[7:0], tx_addr[15:8], tx_addr[23:16],
					tx_addr[31:24], tx_addr[39:32], tx_addr[47:40],
					st_q.seq[7:0], st_q.seq[15:8], st_q.seq[23:16],
					st_q.seq[31:24], 24'h00_0000, 24'h00_0000};
				cipher_start = st_q.ciph_pend;
				st_d.ciph_pend = 1'b0;
				if (cipher_done && !st_q.ciph_pend) begin
					st_d.sig = cipher_result[31:0];
					st_d.state = S_SEND;
					st_d.idx = '0;
				end
			end
			S_SEND: begin
				if (accept) begin
					if (st_q.idx == last_at) begin
						st_d.seq = st_q.seq + 32'h0000_0001;
						st_d.state = S_IDLE;
					end else begin
						st_d.idx = st_q.idx + 6'd1;
					end
				end
			end
		endcase
		// The output byte is registered ahead of need, so the CRC tail
		// uses the next CRC value that already holds the last payload byte.
		if (st_d.state == S_SEND) begin
			st_d.obyte = frame_at(st_d.idx, crc_next);
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '{state: S_IDLE, seq: SEQ_RESET, default: '0};
		end else begin
			st_q <= st_d;
		end
	end
	// The identity key serves the hash, the device key the signature.
	assign cipher_key = (st_q.state == S_HASH) ? irk : device_key;
	assign out_valid = (st_q.state == S_SEND);
	assign out_byte = st_q.obyte;
	assign out_last = out_valid && (st_q.idx == last_at);
	assign busy = (st_q.state != S_IDLE);
	assign seq_count = st_q.seq;
endmodule
`default_nettype wire

// *** sim/bsw_telegram_builder_checker.sv ***
// Port checker for the switch telegram builder.
`timescale 1ns/100ps
`default_nettype none
module bsw_telegram_builder_checker
	import bsw_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic stroke_valid,
	input wire logic commission_req,
	input wire logic busy,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [7:0] out_byte,
	input wire logic out_last,
	input wire logic [31:0] seq_count,
	input wire logic cipher_start,
	input wire bsw_pkg::bsw_ciph_t cipher_mode,
	input wire logic [127:0] cipher_block,
	input wire logic [103:0] cipher_auth,
	input wire logic cipher_done
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_quiet;
		!busy |-> !out_valid && !cipher_start;
	endproperty
	a_quiet: assert property (p_quiet) else $error("idle but active");
	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_byte);
	endproperty
	a_hold: assert property (p_hold) else $error("byte lost");
	property p_end;
		out_valid && out_ready && out_last |=>
			!busy && seq_count == $past(seq_count) + 32'h1;
	endproperty
	a_end: assert property (p_end) else $error("bad frame end");
	property p_order;
		!busy && stroke_valid && !commission_req |=>
			!cipher_start [*2] ##1 cipher_start && !out_valid;
	endproperty
	a_order: assert property (p_order) else $error("bad order");
	property p_comm;
		!busy && commission_req |=> out_valid && out_byte == 8'h42;
	endproperty
	a_comm: assert property (p_comm) else $error("no frame");
	property p_hash;
		cipher_start && cipher_mode == BSW_CIPH_HASH |->
			cipher_block[23:22] == 2'h2 && cipher_block[127:24] == '0;
	endproperty
	a_hash: assert property (p_hash) else $error("bad prand");
	property p_chain;
		cipher_done && cipher_mode == BSW_CIPH_HASH |=>
			cipher_start && cipher_mode == BSW_CIPH_SIGN;
	endproperty
	a_chain: assert property (p_chain) else $error("no sign");
	property p_rsvd;
		cipher_start && cipher_mode == BSW_CIPH_SIGN |->
			cipher_auth[71:69] == 3'h0 && cipher_auth[15:8] == 8'hFF;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("bad auth");
endmodule
bind bsw_telegram_builder bsw_telegram_builder_checker chk_inst (.*);
`default_nettype wire

// *** sim/bsw_far_model.sv ***
// Cipher engine stand-in that answers after a chosen latency.
`timescale 1ns/100ps
`default_nettype none
module bsw_far_model
	import bsw_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cipher_start,
	input wire bsw_pkg::bsw_ciph_t cipher_mode,
	input wire logic [127:0] cipher_key,
	input wire logic [127:0] cipher_block,
	input wire logic [103:0] cipher_auth,
	input wire logic [3:0] lat,
	output logic cipher_done,
	output logic [127:0] cipher_result
);
	logic [3:0] cnt;
	logic pend;
	logic [127:0] res;
	// The result toggles outside the done cycle so a stale read shows.
	always @(posedge core_clk) begin
		cipher_done <= 1'h0;
		cipher_result <= ~cipher_result;
		if (sys_rst) begin
			pend <= 1'h0;
			cipher_result <= 128'h0;
		end else if (cipher_start) begin
			pend <= 1'h1;
			cnt <= lat;
			if (cipher_mode == BSW_CIPH_HASH) begin
				res <= {104'h0, cipher_block[23:0] ^ cipher_key[23:0]};
			end else begin
				res <= cipher_key ^ {24'h0, cipher_auth}
					^ {96'h0, cipher_block[127:96]};
			end
		end else if (pend && cnt == 4'h0) begin
			pend <= 1'h0;
			cipher_done <= 1'h1;
			cipher_result <= res;
		end else if (pend) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the switch telegram builder.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import bsw_pkg::*;
	logic core_clk = 0, sys_rst = 1, stroke_valid = 0, stroke_press = 0;
	logic first_a = 0, second_a = 0, first_b = 0, second_b = 0;
	logic commission_req = 0, rotating_address_select = 0;
	logic irk_override_en = 0, mfr_override_en = 0, out_ready = 0;
	logic cipher_done, out_valid, out_last, busy, cipher_start;
	logic [31:0] static_addr_low = 0, opt_data = 0, seq_count;
	logic [127:0] device_key = 0, irk_cfg = 0, cipher_key, cipher_block;
	logic [127:0] cipher_result;
	logic [103:0] cipher_auth;
	logic [15:0] mfr_code_cfg = 0;
	logic [7:0] out_byte;
	logic [3:0] lat = 0, held = 0;
	logic [23:0] crc, pr_last = 0;
	logic [47:0] addr;
	logic [31:0] seq_m = 0;
	logic rot_chk = 0;
	bsw_opt_t opt_size = BSW_OPT0;
	bsw_ciph_t cipher_mode;
	int n_errors = 0, n_checks = 0, seed = 32'h5f25, idx = 0, e;
	int exp_q[$];
	bsw_telegram_builder bsw_telegram_builder_inst (.*);
	bsw_far_model bsw_far_model_inst (.*);
	always #20 core_clk = ~core_clk;
	// Random stalls keep the builder honest about holding bytes.
	always @(posedge core_clk) out_ready <= ($random(seed) % 4) != 0;
	task automatic cmp(string what, logic [31:0] x, logic [31:0] got);
		n_checks++;
		if (got !== x) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, x, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic pb(int v);
		exp_q.push_back(v);
	endtask
	task automatic pw(logic [31:0] v, int n);
		for (int k = 0; k < n; k++) pb(v[8*k+:8]);
	endtask
	function automatic logic [7:0] sa(int k);
		logic [47:0] a;
		a = {16'h5AA5, static_addr_low};
		return a[8*k+:8];
	endfunction
	task automatic build(logic press, logic [3:0] ct, int os, logic rot,
		logic comm);
		logic [15:0] mfr;
		logic [7:0] len, st;
		logic [31:0] sig;
		int nopt;
		nopt = (os == 3) ? 4 : os;
		len = 8'h0C + 8'(nopt);
		mfr = mfr_override_en ? mfr_code_cfg : 16'h1234;
		// Commissioning never samples contacts, so it leaves the latch alone.
		if (press && !comm) held = ct;
		st = {3'h0, held, press};
		sig = device_key[31:0] ^ {mfr, 8'hFF, len} ^ {static_addr_low[7:0],
			static_addr_low[15:8], static_addr_low[23:16], static_addr_low[31:24]};
		rot_chk = rot && !comm;
		pb(8'h42);
		pb(comm ? 8'h24 : 8'h07 + len);
		for (int k = 0; k < 6; k++) begin
			pb(rot_chk ? 256 : sa(k));
		end
		pb(comm ? 8'h1D : len);
		pb(8'hFF);
		pw(mfr, 2);
		pw(seq_m, 4);
		if (comm) begin
			for (int k = 0; k < 16; k++) pb(device_key[8*k+:8]);
			for (int k = 0; k < 6; k++) pb(sa(k));
		end else begin
			pb(st);
			pw(opt_data, nopt);
			for (int k = 0; k < 4; k++) pb(rot ? 256 : sig[8*k+:8]);
		end
		pb(257);
		pb(258);
		pb(259);
		seq_m++;
		stroke_press <= press;
		{second_b, first_b, second_a, first_a} <= ct;
		opt_size <= bsw_opt_t'(os);
		rotating_address_select <= rot;
		stroke_valid <= !comm || ct[0];
		commission_req <= comm;
		@(posedge core_clk);
		stroke_valid <= 1'h0;
		commission_req <= 1'h0;
		repeat (3) @(posedge core_clk);
		stroke_valid <= 1'h1;
		@(posedge core_clk);
		stroke_valid <= 1'h0;
		for (int w = 0; w < 900 && busy !== 1'h0; w++) @(negedge core_clk);
		cmp("queue", 0, exp_q.size());
		cmp("busy", 0, busy);
		@(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		if (!sys_rst && out_valid === 1'h1 && out_ready) begin
			e = exp_q.size() ? exp_q.pop_front() : 300;
			if (idx == 0) crc = 24'h55_5555;
			if (idx >= 2 && idx < 8) addr[8*(idx-2)+:8] = out_byte;
			if (e >= 257) begin
				cmp("crc", crc[8*(e-257)+:8], out_byte);
			end else begin
				for (int b = 0; b < 8; b++) begin
					crc = {crc[22:0], 1'h0} ^
						((crc[23] ^ out_byte[b]) ? 24'h00_065B : 24'h0);
				end
				if (e != 256) cmp("byte", e, out_byte);
			end
			cmp("last", e == 259, out_last);
			idx = out_last ? 0 : idx + 1;
			if (out_last && rot_chk) begin
				cmp("tag", 2'h2, addr[47:46]);
				cmp("hash", addr[47:24] ^ (irk_override_en ? irk_cfg[23:0]
					: device_key[23:0]), addr[23:0]);
				cmp("fresh", 1, addr[47:24] != pr_last);
				pr_last = addr[47:24];
			end
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'h0;
		for (int i = 0; i < 12; i++) begin
			@(posedge core_clk);
			static_addr_low <= $random(seed);
			opt_data <= $random(seed);
			device_key <= {$random(seed), $random(seed), $random(seed),
				$random(seed)};
			irk_cfg <= {96'h0, $random(seed)};
			mfr_code_cfg <= 16'($random(seed));
			mfr_override_en <= i[1];
			irk_override_en <= i[2];
			lat <= 4'($random(seed));
			@(posedge core_clk);
			build(!i[0], 4'($random(seed)), i % 4, i >= 6,
				i == 4 || i == 9);
		end
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		$display("Error watchdog expected end seen hang");
		tally_and_finish();
	end
endmodule
`default_nettype wire
